// ==== design/clk_div4.sv ====
// Free-running divide-by-four of a clock sampled in the ref clock domain
`timescale 1ns/1ns
`default_nettype none
module clk_div4
(
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic arst_n_i,
  input  wire logic clk_en_i,
  // Clock in and divided clock out
  input  wire logic src_clk_i,
  output logic      div_clk_o
);
  logic [1:0]                          sync;
  logic                                last;
  logic [clk_loss_pkg::DIV_CNT_W-1:0]  cnt;
  logic [1:0]                          next_sync;
  logic                                next_last;
  logic [clk_loss_pkg::DIV_CNT_W-1:0]  next_cnt;
  logic                                next_div;

  // Toggle every two source rising edges: period is four source periods
  always_comb
  begin
    next_sync = {sync[0], src_clk_i};
    next_last = sync[1];
    next_cnt  = cnt;
    next_div  = div_clk_o;
    if (sync[1] && !last)
    begin
      next_cnt = cnt + 2'h1;
      if (cnt[0])
        next_div = ~div_clk_o;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sync      <= 2'h0;
      last      <= 1'b0;
      cnt       <= clk_loss_pkg::DIV_RESET;
      div_clk_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      sync      <= next_sync;
      last      <= next_last;
      cnt       <= next_cnt;
      div_clk_o <= next_div;
    end
  end
endmodule
`default_nettype wire

// ==== design/clk_loss_pkg.sv ====
// Constants for the oscillator clock-loss monitor and clock outputs
package clk_loss_pkg;
  // Oscillator silent for this many RC periods means clock loss
  localparam int unsigned LOSS_PERIODS = 9;
  localparam int unsigned LOSS_CNT_W   = 4;
  localparam logic [LOSS_CNT_W-1:0] LOSS_LIMIT = 4'h9;
  localparam logic [LOSS_CNT_W-1:0] LOSS_CNT_RESET = 4'h0;
  // System clock output divide ratio
  localparam int unsigned DIV_RATIO    = 4;
  localparam int unsigned DIV_CNT_W    = 2;
  localparam logic [DIV_CNT_W-1:0] DIV_RESET = 2'h0;
  // Position of the loss-switch enable bit in the PLL reference select control
  localparam int unsigned PLL_SEL_W    = 9;
  localparam int unsigned LOSS_SWITCH_BIT = 8;
  // Observation clock source select
  localparam int unsigned OBS_SEL_W    = 2;
  localparam int unsigned OBS_SRC_N    = 4;
  // Bit of each clock pin in the pad receiver-active word
  localparam int unsigned PAD_MAIN_DIV = 0;
  localparam int unsigned PAD_MCU_DIV  = 1;
  localparam int unsigned PAD_OBS      = 2;
  localparam int unsigned PAD_MCU_OBS  = 3;
endpackage

// ==== design/osc_clock_loss_monitor.sv ====
// Oscillator clock-loss monitor with reference switch, fault pin and clock outputs
// Behaviour
// RULE1: Clock loss is declared when the oscillator shows no edge for nine RC clock periods.
// RULE2: On clock loss with the loss-switch enable bit set, the reference moves to the RC clock.
// RULE3: While clock loss persists the active-low fault pin is driven low.
// RULE4: The external partner decides on and performs recovery; this block offers none.
// RULE5: Each system clock output is its system clock divided by four.
// RULE6: A clock output pin only drives while its pad receiver-active bit is set.
// RULE7: Each observation clock output carries one selected internal clock, for debug only.
// RULE8: The divided system clock outputs have fixed sources with no selection.
// RULE9: The loss counter clears on each synchronised oscillator edge and otherwise counts up; the code holds it at LOSS_LIMIT once reached.
`timescale 1ns/1ns
`default_nettype none
module osc_clock_loss_monitor
(
  // RC backup clock domain
  input  wire logic                                   ref_clk_i,
  input  wire logic                                   arst_n_i,
  input  wire logic                                   clk_en_i,
  // Monitored oscillator
  input  wire logic                                   main_oscillator_i,
  // PLL reference control
  input  wire logic [clk_loss_pkg::PLL_SEL_W-1:0]     pll_ref_select_ctrl_i,
  output logic                                        ref_is_rc_o,
  output logic                                        clock_loss_o,
  // Fault pin to the partner
  output logic                                        fault_out_n_o,
  // System clocks and divided outputs
  input  wire logic                                   main_system_clock_i,
  input  wire logic                                   mcu_system_clock_i,
  output logic                                        main_div4_clock_out_o,
  output logic                                        main_div4_clock_oe_o,
  output logic                                        mcu_div4_clock_out_o,
  output logic                                        mcu_div4_clock_oe_o,
  // Pad receiver-active bits: main div, mcu div, obs, mcu obs
  input  wire logic [3:0]                             pad_receiver_active_i,
  // Observation clocks
  input  wire logic [clk_loss_pkg::OBS_SRC_N-1:0]     obs_sources_i,
  input  wire logic [clk_loss_pkg::OBS_SEL_W-1:0]     obs_select_i,
  input  wire logic [clk_loss_pkg::OBS_SEL_W-1:0]     mcu_obs_select_i,
  output logic                                        observation_clock_out_o,
  output logic                                        observation_clock_oe_o,
  output logic                                        mcu_observation_clock_out_o,
  output logic                                        mcu_observation_clock_oe_o
);
  logic [1:0]                              osc_sync;
  logic                                    osc_last;
  logic [clk_loss_pkg::LOSS_CNT_W-1:0]     loss_cnt;
  logic [1:0]                              next_osc_sync;
  logic                                    next_osc_last;
  logic [clk_loss_pkg::LOSS_CNT_W-1:0]     next_loss_cnt;
  logic                                    next_loss;
  logic                                    next_ref_rc;
  logic [1:0]                              obs_sync;
  logic [1:0]                              mcu_obs_sync;
  logic [3:0]                              pad_sync1;
  logic [3:0]                              pad_sync2;
  logic [1:0]                              next_obs_sync;
  logic [1:0]                              next_mcu_obs_sync;
  logic                                    main_div;
  logic                                    mcu_div;
  logic                                    next_main_out;
  logic                                    next_mcu_out;
  logic [3:0]                              next_oe;
  logic [3:0]                              next_pad_sync1;
  logic [3:0]                              next_pad_sync2;
  logic                                    next_obs_out;
  logic                                    next_mcu_obs_out;

  function automatic logic pick_src(input logic [clk_loss_pkg::OBS_SRC_N-1:0] src,
                                    input logic [clk_loss_pkg::OBS_SEL_W-1:0] sel);
    pick_src = src[sel];
  endfunction

  // Oscillator synchroniser and edge history
  always_comb
  begin
    next_osc_sync = {osc_sync[0], main_oscillator_i};
    next_osc_last = osc_sync[1];
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      osc_sync <= 2'h0;
      osc_last <= 1'b0;
    end
    else if (clk_en_i)
    begin
      osc_sync <= next_osc_sync;
      osc_last <= next_osc_last;
    end
  end

  // Loss detect: the edge compare adds one cycle on top of the two sync stages
  // Counter saturates at the limit so the loss flag holds until an edge returns
  always_comb
  begin
    next_loss_cnt = loss_cnt;
    if (osc_sync[1] != osc_last)
      next_loss_cnt = clk_loss_pkg::LOSS_CNT_RESET; // RULE9
    else if (loss_cnt != clk_loss_pkg::LOSS_LIMIT)
      next_loss_cnt = loss_cnt + 4'h1; // RULE9
    next_loss   = (next_loss_cnt == clk_loss_pkg::LOSS_LIMIT); // RULE1
    // Once switched the reference stays on RC until reset
    next_ref_rc = ref_is_rc_o
                  | (next_loss & pll_ref_select_ctrl_i[clk_loss_pkg::LOSS_SWITCH_BIT]); // RULE2
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      loss_cnt      <= clk_loss_pkg::LOSS_CNT_RESET;
      clock_loss_o  <= 1'b0;
      fault_out_n_o <= 1'b1;
      ref_is_rc_o   <= 1'b0;
    end
    else if (clk_en_i)
    begin
      loss_cnt      <= next_loss_cnt;
      clock_loss_o  <= next_loss;
      fault_out_n_o <= ~next_loss; // RULE3
      ref_is_rc_o   <= next_ref_rc;
    end
  end

  // Fixed-source divided clocks
  clk_div4 u_main_div
  (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .clk_en_i  (clk_en_i),
    .src_clk_i (main_system_clock_i), // RULE8
    .div_clk_o (main_div)             // RULE5
  );

  clk_div4 u_mcu_div
  (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .clk_en_i  (clk_en_i),
    .src_clk_i (mcu_system_clock_i), // RULE8
    .div_clk_o (mcu_div)             // RULE5
  );

  // Pad receiver-active bits pass two flops before they gate anything
  always_comb
  begin
    next_pad_sync1 = pad_receiver_active_i;
    next_pad_sync2 = pad_sync1;
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pad_sync1 <= 4'h0;
      pad_sync2 <= 4'h0;
    end
    else if (clk_en_i)
    begin
      pad_sync1 <= next_pad_sync1;
      pad_sync2 <= next_pad_sync2;
    end
  end

  // Divided clock outputs; a pad enabled mid-phase can cut the first high phase short
  always_comb
  begin
    next_oe       = pad_sync2; // RULE6
    next_main_out = main_div & pad_sync2[clk_loss_pkg::PAD_MAIN_DIV]; // RULE6
    next_mcu_out  = mcu_div & pad_sync2[clk_loss_pkg::PAD_MCU_DIV];   // RULE6
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      main_div4_clock_out_o <= 1'b0;
      mcu_div4_clock_out_o  <= 1'b0;
      main_div4_clock_oe_o  <= 1'b0;
      mcu_div4_clock_oe_o   <= 1'b0;
    end
    else if (clk_en_i)
    begin
      main_div4_clock_out_o <= next_main_out;
      mcu_div4_clock_out_o  <= next_mcu_out;
      main_div4_clock_oe_o  <= next_oe[clk_loss_pkg::PAD_MAIN_DIV];
      mcu_div4_clock_oe_o   <= next_oe[clk_loss_pkg::PAD_MCU_DIV];
    end
  end

  // Observation clocks are resampled on the RC clock, so their edges are only ref-accurate
  always_comb
  begin
    next_obs_sync     = {obs_sync[0], pick_src(obs_sources_i, obs_select_i)};         // RULE7
    next_mcu_obs_sync = {mcu_obs_sync[0], pick_src(obs_sources_i, mcu_obs_select_i)}; // RULE7
    next_obs_out      = obs_sync[1] & pad_sync2[clk_loss_pkg::PAD_OBS];         // RULE6
    next_mcu_obs_out  = mcu_obs_sync[1] & pad_sync2[clk_loss_pkg::PAD_MCU_OBS]; // RULE6
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      obs_sync                    <= 2'h0;
      mcu_obs_sync                <= 2'h0;
      observation_clock_out_o     <= 1'b0;
      mcu_observation_clock_out_o <= 1'b0;
      observation_clock_oe_o      <= 1'b0;
      mcu_observation_clock_oe_o  <= 1'b0;
    end
    else if (clk_en_i)
    begin
      obs_sync                    <= next_obs_sync;
      mcu_obs_sync                <= next_mcu_obs_sync;
      observation_clock_out_o     <= next_obs_out;
      mcu_observation_clock_out_o <= next_mcu_obs_out;
      observation_clock_oe_o      <= next_oe[clk_loss_pkg::PAD_OBS];
      mcu_observation_clock_oe_o  <= next_oe[clk_loss_pkg::PAD_MCU_OBS];
    end
  end
endmodule
`default_nettype wire

// ==== tb/osc_loss_props.sv ====
// Port assertions for the clock-loss monitor
`timescale 1ns/1ns
`default_nettype none
module osc_loss_props
(
  // Watched ports
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic main_oscillator_i,
  input wire logic [clk_loss_pkg::PLL_SEL_W-1:0] pll_ref_select_ctrl_i,
  input wire logic ref_is_rc_o,
  input wire logic clock_loss_o,
  input wire logic fault_out_n_o,
  input wire logic main_div4_clock_out_o,
  input wire logic main_div4_clock_oe_o,
  input wire logic observation_clock_out_o,
  input wire logic observation_clock_oe_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // Edges since the oscillator input last changed
  logic       osc_q;
  logic [4:0] quiet;
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      osc_q <= 1'h0;
      quiet <= 5'h00;
    end
    else
    begin
      osc_q <= main_oscillator_i;
      quiet <= (main_oscillator_i != osc_q) ? 5'h00 : quiet + 5'(quiet != 5'h1f);
    end
  sequence s_onset;
    $rose(clock_loss_o);
  endsequence
  property p_fault; fault_out_n_o == !clock_loss_o; endproperty
  a_fault: assert property (p_fault) else $error("fault pin");
  property p_early; s_onset |-> quiet >= 5'h09; endproperty
  a_early: assert property (p_early) else $error("early loss");
  property p_late; quiet == 5'h0c |-> clock_loss_o; endproperty
  a_late: assert property (p_late) else $error("late loss");
  property p_clear; clock_loss_o && quiet == 5'h00 |-> ##[1:4] !clock_loss_o; endproperty
  a_clear: assert property (p_clear) else $error("loss stuck");
  property p_cause;
    $rose(ref_is_rc_o) |-> clock_loss_o && $past(pll_ref_select_ctrl_i[clk_loss_pkg::LOSS_SWITCH_BIT]);
  endproperty
  a_cause: assert property (p_cause) else $error("switch cause");
  property p_sticky; ref_is_rc_o |=> ref_is_rc_o; endproperty
  a_sticky: assert property (p_sticky) else $error("switch lost");
  property p_div;
    // A pad enabled mid-phase may give a short first pulse, so only rises with the pad on count
    $rose(main_div4_clock_out_o) && $past(main_div4_clock_oe_o)
      |=> (main_div4_clock_out_o || !main_div4_clock_oe_o)[*8];
  endproperty
  a_div: assert property (p_div) else $error("short high");
  property p_gate; !observation_clock_oe_o |-> !observation_clock_out_o; endproperty
  a_gate: assert property (p_gate) else $error("ungated");
endmodule
bind osc_clock_loss_monitor osc_loss_props u_osc_loss_props
(
  .ref_clk_i               (ref_clk_i),
  .arst_n_i                (arst_n_i),
  .main_oscillator_i       (main_oscillator_i),
  .pll_ref_select_ctrl_i   (pll_ref_select_ctrl_i),
  .ref_is_rc_o             (ref_is_rc_o),
  .clock_loss_o            (clock_loss_o),
  .fault_out_n_o           (fault_out_n_o),
  .main_div4_clock_out_o   (main_div4_clock_out_o),
  .main_div4_clock_oe_o    (main_div4_clock_oe_o),
  .observation_clock_out_o (observation_clock_out_o),
  .observation_clock_oe_o  (observation_clock_oe_o)
);
`default_nettype wire

// ==== tb/pmic_model.sv ====
// Supervisor model that power-cycles the board on a held fault
`timescale 1ns/1ns
`default_nettype none
module pmic_model
(
  // Clock and fault pin
  input  wire logic clk_i,
  input  wire logic fault_n_i,
  // Power-cycle request
  output logic      cycle_o
);
  logic [2:0] held;
  always_ff @(posedge clk_i)
  begin
    held    <= fault_n_i ? 3'h0 : held + 3'h1;
    cycle_o <= (held == 3'h7);
  end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the clock-loss monitor
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic                               clk = 1'h0;
  logic                               rst_n = 1'h0;
  logic                               run = 1'h0;
  logic                               osc = 1'h0;
  logic [clk_loss_pkg::PLL_SEL_W-1:0] sel = '0;
  logic [7:0]                         tick = 8'h00;
  logic [3:0]                         pad = 4'hf;
  logic [1:0]                         os = 2'h0;
  logic [1:0]                         ms = 2'h0;
  logic                               cyc, rc, loss, flt, mo, moe, mc, oo, mco;
  logic                               mce, ooe, mcoe;
  integer                             miscompares, checks;
  wire                                arst_n = rst_n & ~cyc;
  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    #2;
    tick <= tick + 8'h01;
    if (run)
      osc <= ~osc;
  end
  osc_clock_loss_monitor u_osc_clock_loss_monitor
  (
    .ref_clk_i(clk), .arst_n_i(arst_n), .clk_en_i(1'h1),
    .main_oscillator_i(osc), .pll_ref_select_ctrl_i(sel),
    .ref_is_rc_o(rc), .clock_loss_o(loss), .fault_out_n_o(flt),
    .main_system_clock_i(tick[2]), .mcu_system_clock_i(tick[3]),
    .main_div4_clock_out_o(mo), .main_div4_clock_oe_o(moe),
    .mcu_div4_clock_out_o(mc), .mcu_div4_clock_oe_o(mce),
    .pad_receiver_active_i(pad), .obs_sources_i(tick[4:1]),
    .obs_select_i(os), .mcu_obs_select_i(ms),
    .observation_clock_out_o(oo), .observation_clock_oe_o(ooe),
    .mcu_observation_clock_out_o(mco), .mcu_observation_clock_oe_o(mcoe)
  );
  pmic_model u_pmic_model (.clk_i(clk), .fault_n_i(flt), .cycle_o(cyc));
  task automatic stop_test;
    if (miscompares == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // Cycles until the chosen output is seen low and then high
  task automatic rise(input int w, output logic [7:0] n);
    logic [3:0] v;
    logic       lo;
    n = 8'h00;
    lo = 1'h0;
    do
    begin
      step(1);
      n++;
      v = {cyc, mc, mo, loss};
      lo |= !v[w];
    end while (!(lo && v[w]) && n < 8'hc8);
    if (n == 8'hc8)
    begin
      miscompares++;
      stop_test;
    end
  endtask
  task automatic t_loss(input logic en, input logic [7:0] rc_exp);
    logic [7:0] n;
    sel[clk_loss_pkg::LOSS_SWITCH_BIT] <= en;
    run <= 1'h1;
    step(20);
    chk(8'(loss), 8'h00);
    run <= 1'h0;
    rise(0, n);
    // Two sync stages and the edge register come before the count
    chk(n, 8'(clk_loss_pkg::LOSS_PERIODS + 3));
    chk(8'(flt), 8'h00);
    chk(8'(rc), rc_exp);
    run <= 1'h1;
    step(6);
    chk(8'(flt), 8'h01);
  endtask
  task automatic t_div;
    logic [7:0] n;
    rise(1, n);
    rise(1, n);
    chk(n, 8'h20);
    rise(2, n);
    rise(2, n);
    chk(n, 8'h40);
    pad <= 4'h0;
    step(6);
    chk(8'({mo, moe, mc, mce, oo, ooe, mco, mcoe}), 8'h00);
    pad <= 4'hf;
    step(4);
    chk(8'({moe, mce, ooe, mcoe}), 8'h0f);
  endtask
  task automatic t_obs;
    logic [7:0] a, b;
    logic       po, pm;
    for (int s = 0; s < 4; s++)
    begin
      os <= 2'(s);
      ms <= 2'(3 - s);
      step(8);
      a = 8'h00;
      b = 8'h00;
      po = oo;
      pm = mco;
      repeat (64)
      begin
        step(1);
        a += 8'(oo != po);
        b += 8'(mco != pm);
        po = oo;
        pm = mco;
      end
      chk(a, 8'h20 >> s);
      chk(b, 8'h20 >> (3 - s));
    end
  endtask
  task automatic t_recover;
    logic [7:0] n;
    run <= 1'h0;
    rise(3, n);
    chk(8'({rc, flt}), 8'h01);
  endtask
  initial
  begin
    miscompares = 0;
    checks = 0;
    step(8);
    rst_n <= 1'h1;
    step(2);
    t_loss(1'h0, 8'h00);
    t_loss(1'h1, 8'h01);
    t_div;
    t_obs;
    t_recover;
    stop_test;
  end
endmodule
`default_nettype wire
